// *** pkg/rwdt_pkg.sv ***
// constants and helpers shared by the runaway monitor
package rwdt_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets on the bus
    localparam logic [7:0] OFS_MODE     = 8'h00;
    localparam logic [7:0] OFS_CMD      = 8'h04;
    localparam logic [7:0] OFS_NMIF     = 8'h08;
    localparam logic [7:0] OFS_GEAR     = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFS_COUNT    = 8'h18;
    localparam logic [7:0] OFS_STATUS   = 8'h1c;

    ////////////////////////////////////////////////////////////////////////
    // monitor_mode_reg fields
    localparam int         MODE_EN_BIT   = 7;
    localparam int         MODE_SEL_LSB  = 4;
    localparam int         MODE_IDLE_BIT = 2;
    localparam int         MODE_ACT_BIT  = 1;
    localparam logic [7:0] MODE_WMASK    = 8'hf6;
    localparam logic [7:0] MODE_RESET    = 8'h82;

    // monitor_cmd_reg codes
    localparam logic [7:0] CMD_CLEAR     = 8'h4e;
    localparam logic [7:0] CMD_DISABLE   = 8'hb1;

    // nmi_source_flags and interrupt status layout
    localparam int         NMIF_MON_BIT  = 0;
    localparam int         IRQ_OVF_BIT   = 0;
    localparam int         IRQ_CLR_BIT   = 1;
    localparam int         IRQ_DIS_BIT   = 2;
    localparam int         IRQ_W         = 3;
    localparam logic [2:0] IRQ_RESET     = 3'h0;
    localparam logic [2:0] GEAR_RESET    = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int         CNT_W         = 25;
    localparam int         EXP_BASE      = 15;
    localparam int         EXP_STEP      = 2;
    localparam logic [2:0] SEL_MAX       = 3'h5;
    localparam int         HOLD_STATES   = 32;
    localparam int         HOLD_CYCLES   = HOLD_STATES;

    // terminal count for a period select; codes above the longest saturate
    function automatic logic [CNT_W-1:0] rwdt_limit(input logic [2:0] sel);
        logic [2:0]     s;
        logic [4:0]     sh;
        logic [CNT_W:0] p;
        logic [CNT_W:0] t;
        s  = (sel > SEL_MAX) ? SEL_MAX : sel;
        sh = 5'(EXP_BASE + EXP_STEP * int'(s));
        p  = {{CNT_W{1'b0}}, 1'b1} << sh;
        t  = p - {{CNT_W{1'b0}}, 1'b1};
        return t[CNT_W-1:0];
    endfunction

endpackage

// *** hw/rwdt_counter.sv ***
// binary counter of the runaway monitor with period select
`timescale 1ns/10ps
`default_nettype none
module rwdt_counter #(
    parameter int CNT_W = rwdt_pkg::CNT_W
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    // control
    input  wire logic             clear,
    input  wire logic             run,
    input  wire logic [2:0]       sel,
    // results
    output logic                  ovf,
    output logic [CNT_W-1:0]      count
);

    logic [CNT_W-1:0] limit;

    assign limit = CNT_W'(rwdt_pkg::rwdt_limit(sel));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            ovf   <= 1'b0;
        end else if (ce) begin
            ovf <= 1'b0;
            if (clear) begin
                count <= '0;
            end else if (run) begin
                if (count >= limit) begin
                    count <= '0;
                    ovf   <= 1'b1;
                end else begin
                    count <= count + 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// *** hw/rwdt_hold.sv ***
// stretcher that holds the internal reset for a fixed number of states
`timescale 1ns/10ps
`default_nettype none
module rwdt_hold #(
    parameter int HOLD = rwdt_pkg::HOLD_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    // trigger and output
    input  wire logic start,
    output logic      active
);

    typedef enum logic {RWDT_HS_IDLE, RWDT_HS_HOLD} rwdt_hold_t;

    rwdt_hold_t state;
    logic [7:0] cnt;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state  <= RWDT_HS_IDLE;
            cnt    <= 8'h00;
            active <= 1'b0;
        end else if (ce) begin
            unique case (state)
                RWDT_HS_IDLE: begin
                    if (start) begin
                        state  <= RWDT_HS_HOLD;
                        cnt    <= 8'h00;
                        active <= 1'b1;
                    end
                end
                RWDT_HS_HOLD: begin
                    if (cnt == 8'(HOLD - 1)) begin
                        state  <= RWDT_HS_IDLE;
                        active <= 1'b0;
                    end else begin
                        cnt <= cnt + 8'h01;
                    end
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// *** hw/rwdt_top.sv ***
// runaway monitor top: bus slave, control registers and overflow actions
`timescale 1ns/10ps
`default_nettype none
module rwdt_top #(
    parameter int CNT_W = rwdt_pkg::CNT_W,
    parameter int HOLD  = rwdt_pkg::HOLD_CYCLES
) (
    // clock, reset, clock enable
    input  wire logic        CLK_SYS,
    input  wire logic        RESETN,
    input  wire logic        CE,
    // ahb-lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic [31:0]      HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // processor state
    input  wire logic        DEBUG_HALT,
    input  wire logic        IDLE_MODE,
    // overflow actions
    output logic             NMI_REQ,
    output logic             SYS_RESET,
    output logic [2:0]       GEAR_SEL,
    output logic             IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic [7:0]             mode;
    logic                   run;
    logic                   nmi_flag;
    logic [2:0]             gear;
    logic [2:0]             irq_stat;
    logic [2:0]             irq_mask;

    logic                   wr_pend;
    logic [7:0]             wr_addr;
    logic                   addr_ok;
    logic [7:0]             rd_addr;

    logic                   wr_now;
    logic [7:0]             wdat;
    logic                   wr_mode;
    logic                   wr_cmd;
    logic                   wr_nmif;
    logic                   wr_gear;
    logic                   wr_stat;
    logic                   wr_mask;

    logic                   cmd_clear;
    logic                   cmd_disable;
    logic                   mode_en;
    logic                   mode_idle;
    logic                   mode_act;
    logic [2:0]             mode_sel;

    logic                   wrst;
    logic                   cnt_run;
    logic                   cnt_clear;
    logic                   ovf;
    logic                   ovf_nmi;
    logic                   ovf_rst;
    logic [CNT_W-1:0]       count;
    logic [2:0]             next_irq_stat;

    // offset match used by every register write select
    function automatic logic rwdt_hit(input logic [7:0] a,
                                      input logic [7:0] ofs);
        return a == ofs;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // field views of the mode register

    assign mode_en   = mode[rwdt_pkg::MODE_EN_BIT];
    assign mode_idle = mode[rwdt_pkg::MODE_IDLE_BIT];
    assign mode_act  = mode[rwdt_pkg::MODE_ACT_BIT];
    assign mode_sel  = mode[rwdt_pkg::MODE_SEL_LSB +: 3];

    ////////////////////////////////////////////////////////////////////////
    // bus slave: address phase capture

    // wait states only while frozen, so no transfer is lost under ce low
    assign HREADYOUT = CE;
    assign HRESP     = 1'b0;

    // hsize is not decoded: every register is one aligned word
    // and address bits above 7 are ignored
    assign addr_ok = HSEL & HTRANS[1] & HREADY;
    assign rd_addr = {HADDR[7:2], 2'b00};

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else if (CE) begin
            wr_pend <= addr_ok & HWRITE;
            if (addr_ok & HWRITE) begin
                wr_addr <= rd_addr;
            end
        end
    end

    // write data phase decode
    assign wr_now  = wr_pend & CE;
    assign wdat    = HWDATA[7:0];
    assign wr_mode = wr_now & rwdt_hit(wr_addr, rwdt_pkg::OFS_MODE);
    assign wr_cmd  = wr_now & rwdt_hit(wr_addr, rwdt_pkg::OFS_CMD);
    assign wr_nmif = wr_now & rwdt_hit(wr_addr, rwdt_pkg::OFS_NMIF);
    assign wr_gear = wr_now & rwdt_hit(wr_addr, rwdt_pkg::OFS_GEAR);
    assign wr_stat = wr_now & rwdt_hit(wr_addr, rwdt_pkg::OFS_IRQ_STAT);
    assign wr_mask = wr_now & rwdt_hit(wr_addr, rwdt_pkg::OFS_IRQ_MASK);

    // command decode; unknown codes decode to nothing
    // disable looks at the enable bit as stored before this write
    assign cmd_clear   = wr_cmd & (wdat == rwdt_pkg::CMD_CLEAR);
    assign cmd_disable = wr_cmd & (wdat == rwdt_pkg::CMD_DISABLE)
                         & ~mode_en;

    ////////////////////////////////////////////////////////////////////////
    // read data, registered in the address phase
    // a read right after a write to the same register sees the old value

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            HRDATA <= 32'h0000_0000;
        end else if (CE) begin
            if (addr_ok & ~HWRITE) begin
                unique case (rd_addr)
                    rwdt_pkg::OFS_MODE:     HRDATA <= {24'h0, mode};
                    rwdt_pkg::OFS_NMIF:     HRDATA <= {31'h0, nmi_flag};
                    rwdt_pkg::OFS_GEAR:     HRDATA <= {29'h0, gear};
                    rwdt_pkg::OFS_IRQ_STAT: HRDATA <= {29'h0, irq_stat};
                    rwdt_pkg::OFS_IRQ_MASK: HRDATA <= {29'h0, irq_mask};
                    rwdt_pkg::OFS_COUNT:    HRDATA <= 32'(count);
                    rwdt_pkg::OFS_STATUS:   HRDATA <= {31'h0, run};
                    // command register is write only; unmapped reads zero
                    default:                HRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // internal reset from the monitor

    assign ovf_nmi = ovf & ~mode_act;
    assign ovf_rst = ovf & mode_act;

    rwdt_hold #(
        .HOLD   (HOLD)
    ) u_hold (
        .clk    (CLK_SYS),
        .rst_n  (RESETN),
        .ce     (CE),
        .start  (ovf_rst),
        .active (wrst)
    );

    // chip reset request lasts the full hold
    assign SYS_RESET = wrst;

    ////////////////////////////////////////////////////////////////////////
    // mode register

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            mode <= rwdt_pkg::MODE_RESET;
        end else if (CE) begin
            if (wrst) begin
                mode <= rwdt_pkg::MODE_RESET;
            end else if (wr_mode) begin
                mode <= wdat & rwdt_pkg::MODE_WMASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // run state: set by the enable bit, cleared only by the disable sequence

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            run <= 1'b1;
        end else if (CE) begin
            if (wrst) begin
                run <= 1'b1;
            end else if (wr_mode & wdat[rwdt_pkg::MODE_EN_BIT]) begin
                run <= 1'b1;
            end else if (cmd_disable) begin
                run <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counter

    // debug halt and idle gate counting; stop mode is left to software:
    // the clock stops there, so the monitor must be off before entry
    assign cnt_run = run & ~wrst & ~DEBUG_HALT
                     & (~IDLE_MODE | mode_idle);
    assign cnt_clear = wrst | cmd_clear | cmd_disable;

    rwdt_counter #(
        .CNT_W  (CNT_W)
    ) u_counter (
        .clk    (CLK_SYS),
        .rst_n  (RESETN),
        .ce     (CE),
        .clear  (cnt_clear),
        .run    (cnt_run),
        .sel    (mode_sel),
        .ovf    (ovf),
        .count  (count)
    );

    ////////////////////////////////////////////////////////////////////////
    // nmi request and source flag
    // no external runaway pin: overflow acts only through these, the interrupt status and reset

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            NMI_REQ <= 1'b0;
        end else if (CE) begin
            NMI_REQ <= ovf_nmi & ~wrst;
        end
    end

    // set beats a same-cycle clear
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            nmi_flag <= 1'b0;
        end else if (CE) begin
            if (wrst) begin
                nmi_flag <= 1'b0;
            end else if (ovf_nmi) begin
                nmi_flag <= 1'b1;
            end else if (wr_nmif & wdat[rwdt_pkg::NMIF_MON_BIT]) begin
                nmi_flag <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock gear register

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            gear <= rwdt_pkg::GEAR_RESET;
        end else if (CE) begin
            if (wrst) begin
                gear <= rwdt_pkg::GEAR_RESET;
            end else if (wr_gear) begin
                gear <= wdat[2:0];
            end
        end
    end

    assign GEAR_SEL = gear;

    ////////////////////////////////////////////////////////////////////////
    // interrupt status and mask

    always_comb begin
        next_irq_stat = irq_stat;
        if (wr_stat) begin
            next_irq_stat = irq_stat & ~wdat[2:0];
        end
        // events are applied after the clear so a set wins
        if (ovf_nmi) begin
            next_irq_stat[rwdt_pkg::IRQ_OVF_BIT] = 1'b1;
        end
        if (cmd_clear) begin
            next_irq_stat[rwdt_pkg::IRQ_CLR_BIT] = 1'b1;
        end
        if (cmd_disable) begin
            next_irq_stat[rwdt_pkg::IRQ_DIS_BIT] = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            irq_stat <= rwdt_pkg::IRQ_RESET;
        end else if (CE) begin
            if (wrst) begin
                irq_stat <= rwdt_pkg::IRQ_RESET;
            end else begin
                irq_stat <= next_irq_stat;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            irq_mask <= rwdt_pkg::IRQ_RESET;
        end else if (CE) begin
            if (wrst) begin
                irq_mask <= rwdt_pkg::IRQ_RESET;
            end else if (wr_mask) begin
                irq_mask <= wdat[2:0];
            end
        end
    end

    // irq follows the next status so it rises with the status bit
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            IRQ <= 1'b0;
        end else if (CE) begin
            IRQ <= |(next_irq_stat & irq_mask) & ~wrst;
        end
    end

endmodule
`default_nettype wire

// *** test/rwdt_top_chk.sv ***
// port-level assertions for the runaway monitor top
`timescale 1ns/10ps
`default_nettype none
module rwdt_top_chk #(
    parameter int CNT_W = rwdt_pkg::CNT_W,
    parameter int HOLD  = rwdt_pkg::HOLD_CYCLES
) (
    // clock, reset, clock enable
    input  wire logic       CLK_SYS,
    input  wire logic       RESETN,
    input  wire logic       CE,
    // bus answer
    input  wire logic       HREADYOUT,
    input  wire logic       HRESP,
    // overflow actions
    input  wire logic       NMI_REQ,
    input  wire logic       SYS_RESET,
    input  wire logic [2:0] GEAR_SEL,
    input  wire logic       IRQ
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESETN);

    ////////////////////////////////////////////////////////////////////////
    // counts the cycles the internal reset stands
    logic [7:0] hold_len;

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            hold_len <= 8'h00;
        end else if (!SYS_RESET) begin
            hold_len <= 8'h00;
        end else if (CE) begin
            hold_len <= hold_len + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    hresp_okay_a: assert property (HRESP == 1'b0)
        else $error("bus response not okay");
    ready_ce_a: assert property (HREADYOUT == CE)
        else $error("ready does not follow clock enable");
    nmi_pulse_a: assert property (NMI_REQ && CE |=> !NMI_REQ)
        else $error("runaway interrupt longer than one cycle");
    reset_len_a: assert property ($fell(SYS_RESET) |-> int'(hold_len) == HOLD)
        else $error("internal reset length wrong");
    reset_gap_a: assert property ($fell(SYS_RESET) |=> !SYS_RESET [*8])
        else $error("internal reset repeated at once");
    reset_nmi_a: assert property (SYS_RESET |-> !NMI_REQ)
        else $error("interrupt raised with reset action");
    reset_gear_a: assert property (SYS_RESET && $past(SYS_RESET) |-> GEAR_SEL == 3'h0)
        else $error("clock gear not undivided in reset");
    reset_irq_a: assert property (SYS_RESET && $past(SYS_RESET, 2) |-> !IRQ)
        else $error("interrupt stands through internal reset");
endmodule

bind rwdt_top rwdt_top_chk #(.CNT_W(CNT_W), .HOLD(HOLD)) i_chk (
    .CLK_SYS   (CLK_SYS),
    .RESETN    (RESETN),
    .CE        (CE),
    .HREADYOUT (HREADYOUT),
    .HRESP     (HRESP),
    .NMI_REQ   (NMI_REQ),
    .SYS_RESET (SYS_RESET),
    .GEAR_SEL  (GEAR_SEL),
    .IRQ       (IRQ)
);
`default_nettype wire

// *** test/rwdt_top_tb.sv ***
// self-checking bench for the runaway monitor top
`timescale 1ns/10ps
`default_nettype none
module rwdt_top_tb;
    logic        clk        = 1'b0;
    logic        resetn     = 1'b0;
    logic        ce         = 1'b1;
    logic        hsel       = 1'b0;
    logic [31:0] haddr      = 32'h0;
    logic [1:0]  htrans     = 2'h0;
    logic        hwrite     = 1'b0;
    logic [31:0] hwdata     = 32'h0;
    logic        debug_halt = 1'b0;
    logic        idle_mode  = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        nmi_req;
    logic        sys_reset;
    logic [2:0]  gear_sel;
    logic        irq;
    int          failures = 0;
    int          samples_checked = 0;
    int          n;
    logic [31:0] r1;
    logic [31:0] r2;
    logic [7:0]  ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c,
                             8'h10, 8'h14, 8'h1c, 8'h20};
    logic [31:0] rst [8] = '{32'h82, 32'h0, 32'h0, 32'h0,
                             32'h0, 32'h0, 32'h1, 32'h0};

    always #5 clk = ~clk;

    rwdt_top i_dut (
        .CLK_SYS(clk), .RESETN(resetn), .CE(ce), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
        .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .DEBUG_HALT(debug_halt),
        .IDLE_MODE(idle_mode), .NMI_REQ(nmi_req), .SYS_RESET(sys_reset),
        .GEAR_SEL(gear_sel), .IRQ(irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // one single transfer; entered right after a rising edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        bus(1'b0, a, 32'h0, r);
    endtask

    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", s, e, g);
            failures++;
        end
    endtask

    task automatic rc(input string s, input logic [7:0] a,
                      input logic [31:0] e);
        logic [31:0] r;
        rd(a, r);
        chk(s, e, r);
    endtask

    task automatic test_done;
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        foreach (ofs[i]) rc("reset value", ofs[i], rst[i]);
        wr(8'h20, 32'hff);
        rc("unmapped", 8'h20, 32'h0);
        wr(8'h00, 32'hff);
        rc("mode mask", 8'h00, 32'hf6);
        wr(8'h00, 32'h82);
        // counting, clear code and a foreign code
        rd(8'h18, r1);
        rd(8'h18, r2);
        chk("count step", 32'h2, r2 - r1);
        wr(8'h04, 32'h4e);
        rd(8'h18, r1);
        chk("count clear", 32'h0, r1);
        wr(8'h04, 32'h12);
        rd(8'h18, r2);
        chk("count kept", 32'h4, r2 - r1);
        rc("running", 8'h1c, 32'h1);
        // clock enable low freezes counting and stalls the bus
        rd(8'h18, r1);
        ce <= 1'b0;
        fork
            begin
                repeat (10) @(posedge clk);
                ce <= 1'b1;
            end
        join_none
        rd(8'h18, r2);
        chk("ce freeze", 32'h2, r2 - r1);
        // disable only after the enable bit is cleared
        wr(8'h04, 32'hb1);
        rc("running", 8'h1c, 32'h1);
        wr(8'h00, 32'h02);
        rc("running", 8'h1c, 32'h1);
        wr(8'h04, 32'hb1);
        rc("running", 8'h1c, 32'h0);
        rc("count", 8'h18, 32'h0);
        // sticky events, mask and write-one clear
        chk("irq", 32'h0, irq);
        wr(8'h14, 32'h4);
        rc("stat", 8'h10, 32'h6);
        chk("irq", 32'h1, irq);
        wr(8'h10, 32'h4);
        rc("stat", 8'h10, 32'h2);
        chk("irq", 32'h0, irq);
        wr(8'h00, 32'h82);
        rc("running", 8'h1c, 32'h1);
        // debug halt and idle
        debug_halt <= 1'b1;
        rd(8'h18, r1);
        rd(8'h18, r2);
        chk("debug stop", r1, r2);
        debug_halt <= 1'b0;
        idle_mode  <= 1'b1;
        rd(8'h18, r1);
        rd(8'h18, r2);
        chk("idle stop", r1, r2);
        wr(8'h00, 32'h86);
        rd(8'h18, r1);
        rd(8'h18, r2);
        chk("idle run", 32'h2, r2 - r1);
        idle_mode <= 1'b0;
        // select 001 lasts beyond 2^15 cycles
        wr(8'h00, 32'h90);
        wr(8'h04, 32'h4e);
        n = 0;
        repeat (32800) begin
            @(posedge clk);
            if (nmi_req !== 1'b0) n++;
        end
        chk("sel1 nmi", 32'h0, n);
        rd(8'h18, r1);
        chk("sel1 count", 32'h1, r1 > 32'h8000);
        // shortest period with interrupt action
        wr(8'h04, 32'h4e);
        wr(8'h00, 32'h80);
        n = 0;
        while (nmi_req !== 1'b1 && n < 33000) begin
            @(posedge clk);
            n++;
        end
        chk("nmi time", 32'h1, n > 32760 && n < 32772);
        rc("nmi flag", 8'h08, 32'h1);
        wr(8'h08, 32'h1);
        rc("nmi flag", 8'h08, 32'h0);
        wr(8'h14, 32'h1);
        rc("stat", 8'h10, 32'h3);
        chk("irq", 32'h1, irq);
        // reset action restores gear and registers
        wr(8'h0c, 32'h4);
        rc("gear", 8'h0c, 32'h4);
        wr(8'h00, 32'h82);
        wr(8'h04, 32'h4e);
        n = 0;
        while (sys_reset !== 1'b1 && n < 33000) begin
            @(posedge clk);
            n++;
        end
        chk("reset time", 32'h1, n > 32760 && n < 32772);
        n = 0;
        while (sys_reset === 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk("reset hold", 32'd32, n);
        chk("gear pin", 32'h0, gear_sel);
        rc("gear", 8'h0c, 32'h0);
        rc("mode", 8'h00, 32'h82);
        rc("mask", 8'h14, 32'h0);
        chk("irq", 32'h0, irq);
        // software turns the monitor off before a clock stop
        wr(8'h00, 32'h02);
        wr(8'h04, 32'hb1);
        rc("stopped", 8'h1c, 32'h0);
        test_done();
    end
endmodule
`default_nettype wire
